/* pcr_bank.sv */
// Plug and Play configuration and command register bank with AXI4-Lite access
// Summary of operation
// R1: Register read_port_address holds read data port address
// R2: Register isolation_register serves card isolation
// R3: Control bit 2 clears card select number
// R4: Control bit 1 returns to wait-for-key
// R5: Control bit 0 resets all logical devices
// R6: Wake write matches card number to wake
// R7: Register resource_byte returns next EEPROM resource byte
// R8: Register resource_status bit 0 reports byte ready
// R9: Register card_select_number holds assigned card number
// R10: Register device_activate bit 0 activates device
// R11: Register io_range_check bits 1:0 enable range check; the bits are only stored and read back, and no range check acts on them
// R12: I/O field matches address bits 8..5
// R13: Base, DMA, PROM fields load from EEPROM
// R14: Interrupt code selects ISA line, 3 default
// R15: No interrupt line driven before activate
// R16: Type bit: one level, zero edge
// R17: Polarity indicator reads inverse of type
// R18: DMA code selects channel; 100 none
// R19: No DMA request before activate
// R20: PROM field matches address bits 16..13
// R21: Legacy bit ignores standard key, accepts vendor
// R22: Bad EEPROM still accepts vendor key
// R23: Software prefers legacy bit in EEPROM
// R24: Legacy off: standard key only if EEPROM good
// R25: Constant bits read fixed, ignore writes
//
// Design decision made here: the AXI4-Lite register port.
module pcr_bank
   import pcr_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic [9:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [9:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [7:0] key_byte, // Key byte seen on address port
   input wire logic key_strobe, // One-cycle strobe with key_byte
   input wire logic isolation_bit, // Isolation bit from bus sampling
   input wire logic eeprom_done, // EEPROM load finished
   input wire logic eeprom_ok, // EEPROM checksum good
   input wire pcr_load_t eeprom_load, // Fields from EEPROM
   input wire pcr_res_t res_in, // Resource byte from EEPROM reader
   output logic res_take, // Resource byte consumed
   input wire logic [19:0] host_addr, // Host address pins
   input wire logic dev_irq, // Controller interrupt request
   input wire logic dev_drq, // Controller DMA request
   input wire logic bus_master, // Bus master mode strap
   output logic [7:0] irq_lines, // Lines 3,4,5,9,10,11,13,14
   output logic [3:0] drq_lines, // Channels 3,5,6,7
   output logic logical_reset, // Reset pulse to logical devices
   output logic io_hit, // I/O window hit
   output logic rom_hit, // PROM window hit
   output logic [1:0] cfg_state, // Configuration state
   output logic [7:0] vendor_opts // Vendor byte to the controller
);
   localparam logic [7:0] ISO_MASK = 8'h01;

   pcr_state_t state_q, state_d;
   logic [7:0] read_port_q, csn_q, ldn_q, vendor_q, iso_q;
   logic [3:0] io_base_q, irq_sel_q, rom_base_q;
   logic [2:0] dma_sel_q;
   logic irq_type_q, active_q, rom_wide_q, sm_wide_q;
   logic [1:0] io_range_check_enable_q;
   logic [4:0] sm_base_q;
   logic [3:0] rom_size_q, sm_size_q;
   logic aw_q, w_q;
   logic [7:0] aw_idx_q;
   logic [7:0] wd_q;
   logic loaded_q;
   logic [7:0] irq_q;
   logic [3:0] drq_q;
   logic rst_pulse_q, res_take_q;

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   wire logic aw_fire = s_axi_awvalid & s_axi_awready;
   wire logic w_fire = s_axi_wvalid & s_axi_wready;
   wire logic [7:0] aw_idx_now = aw_fire ? s_axi_awaddr[9:2] : aw_idx_q;
   wire logic [7:0] wd_now = w_fire ? s_axi_wdata[7:0] : wd_q;
   wire logic have_aw = aw_q | aw_fire;
   wire logic have_w = w_q | w_fire;
   wire logic wr_go = have_aw & have_w & ~s_axi_bvalid;
   logic wr_lane_q;
   wire logic wr_lane = w_fire ? s_axi_wstrb[0] : wr_lane_q; // Held while data waits for address
   wire logic wr_en = wr_go & wr_lane;
   wire logic in_config = (state_q == PCR_CONFIG);

   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = (idx <= IDX_LDN) || (idx == IDX_ACTIVATE) || (idx == IDX_IO_RANGE_CHECK_ENABLE) ||
         (idx >= IDX_ROM_HI && idx <= IDX_ROM_SZ_LO) || (idx >= IDX_SM_HI && idx <= IDX_SM_SZ_LO) ||
         (idx == IDX_IO_HI) || (idx == IDX_IO_LO) || (idx == IDX_IRQ_SEL) ||
         (idx == IDX_IRQ_SIG) || (idx == IDX_DMA_SEL) || (idx == IDX_VENDOR);
   endfunction

   function automatic logic wr_hit(input logic en, input logic [7:0] idx, input logic [7:0] want);
      wr_hit = en && (idx == want);
   endfunction

   wire logic wr_ctl = wr_hit(wr_en, aw_idx_now, IDX_CFG_CTRL);
   wire logic do_clr_csn = wr_ctl & wd_now[CTL_CLR_CSN_BIT]; // R3
   wire logic do_wait_key = wr_ctl & wd_now[CTL_WAIT_KEY_BIT]; // R4
   wire logic do_rst_all = wr_ctl & wd_now[CTL_RST_ALL_BIT]; // R5
   wire logic wr_wake = wr_hit(wr_en, aw_idx_now, IDX_WAKE);
   wire logic wake_match = wr_wake && (wd_now == csn_q); // R6
   wire logic cfg_wr = in_config & wr_en; // Resource fields writable in config only

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         aw_idx_q <= BYTE_ZERO;
         wd_q <= BYTE_ZERO;
         wr_lane_q <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         aw_q <= have_aw & ~wr_go;
         w_q <= have_w & ~wr_go;
         aw_idx_q <= aw_idx_now;
         wd_q <= wd_now;
         wr_lane_q <= wr_lane;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_idx_now) ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_q & ~s_axi_bvalid;

   // ----------------------------------------
   // Key and wake state machine
   // ----------------------------------------
   // Standard key only after a good EEPROM and with legacy off; vendor key always
   wire logic std_key_ok = ~vendor_q[VND_LEGACY_BIT] & eeprom_ok & loaded_q; // R21 R24
   wire logic key_hit = key_strobe &&
      ((key_byte == KEY_VENDOR) || (std_key_ok && key_byte == KEY_STANDARD)); // R22

   always_comb begin
      state_d = state_q;
      case (state_q)
         PCR_WAIT_KEY: begin
            if (key_hit) begin
               state_d = PCR_SLEEP;
            end
         end
         PCR_SLEEP: begin
            if (wake_match) begin
               state_d = (csn_q == BYTE_ZERO) ? PCR_ISOLATE : PCR_CONFIG; // R6
            end
         end
         PCR_ISOLATE, PCR_CONFIG: begin
            if (wr_wake && !wake_match) begin
               state_d = PCR_SLEEP;
            end
         end
         default: state_d = PCR_WAIT_KEY;
      endcase
      if (wr_hit(wr_en, aw_idx_now, IDX_CSN) && state_q == PCR_ISOLATE) begin
         state_d = PCR_CONFIG;
      end
      if (do_wait_key) begin
         state_d = PCR_WAIT_KEY; // R4
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= PCR_WAIT_KEY;
         read_port_q <= BYTE_ZERO;
         csn_q <= BYTE_ZERO;
         ldn_q <= BYTE_ZERO;
         iso_q <= BYTE_ZERO;
         active_q <= 1'b0;
         io_range_check_enable_q <= 2'h0;
         loaded_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (eeprom_done) begin
            loaded_q <= 1'b1;
         end
         if (wr_hit(wr_en, aw_idx_now, IDX_READ_PORT)) begin
            read_port_q <= wd_now; // R1
         end
         if (state_q == PCR_ISOLATE) begin
            iso_q <= {7'h00, isolation_bit}; // R2
         end
         if (do_clr_csn) begin
            csn_q <= BYTE_ZERO; // R3
         end else if (wr_hit(wr_en, aw_idx_now, IDX_CSN)) begin
            csn_q <= wd_now; // R9
         end
         if (wr_hit(cfg_wr, aw_idx_now, IDX_LDN)) begin
            ldn_q <= wd_now;
         end
         if (do_rst_all) begin
            active_q <= 1'b0; // R5
            io_range_check_enable_q <= 2'h0;
         end else begin
            if (wr_hit(cfg_wr, aw_idx_now, IDX_ACTIVATE)) begin
               active_q <= wd_now[0]; // R10
            end
            if (wr_hit(cfg_wr, aw_idx_now, IDX_IO_RANGE_CHECK_ENABLE)) begin
               io_range_check_enable_q <= wd_now[1:0]; // R11
            end
         end
      end
   end

   // Resource fields: EEPROM load wins over a write in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         io_base_q <= 4'h0;
         irq_sel_q <= IRQ_SEL_RST; // R14
         irq_type_q <= 1'b0; // R16
         dma_sel_q <= DMA_SEL_RST;
         rom_base_q <= 4'h0;
         rom_wide_q <= 1'b0;
         rom_size_q <= 4'h0;
         sm_base_q <= 5'h00;
         sm_wide_q <= 1'b0;
         sm_size_q <= 4'h0;
         vendor_q <= BYTE_ZERO;
      end else if (eeprom_done && eeprom_ok) begin
         io_base_q <= eeprom_load.io_base_match; // R13
         irq_sel_q <= eeprom_load.irq_sel;
         irq_type_q <= eeprom_load.irq_type;
         dma_sel_q <= eeprom_load.dma_sel; // R13
         rom_base_q <= eeprom_load.rom_base_match; // R13
         vendor_q <= eeprom_load.vendor & 8'h7f; // R23
      end else if (cfg_wr) begin
         if (aw_idx_now == IDX_IO_HI) begin
            io_base_q[3] <= wd_now[0]; // R25
         end else if (aw_idx_now == IDX_IO_LO) begin
            io_base_q[2:0] <= wd_now[7:5];
         end else if (aw_idx_now == IDX_IRQ_SEL) begin
            irq_sel_q <= wd_now[3:0];
         end else if (aw_idx_now == IDX_IRQ_SIG) begin
            irq_type_q <= wd_now[0]; // R16
         end else if (aw_idx_now == IDX_DMA_SEL) begin
            dma_sel_q <= wd_now[2:0];
         end else if (aw_idx_now == IDX_ROM_HI) begin
            rom_base_q[3] <= wd_now[0];
         end else if (aw_idx_now == IDX_ROM_LO) begin
            rom_base_q[2:0] <= wd_now[7:5];
         end else if (aw_idx_now == IDX_ROM_WIDTH) begin
            rom_wide_q <= wd_now[1];
         end else if (aw_idx_now == IDX_ROM_SZ_HI) begin
            rom_size_q[3] <= wd_now[0];
         end else if (aw_idx_now == IDX_ROM_SZ_LO) begin
            rom_size_q[2:0] <= wd_now[7:5];
         end else if (aw_idx_now == IDX_SM_HI) begin
            sm_base_q[4:3] <= wd_now[1:0];
         end else if (aw_idx_now == IDX_SM_LO) begin
            sm_base_q[2:0] <= wd_now[7:5];
         end else if (aw_idx_now == IDX_SM_WIDTH) begin
            sm_wide_q <= wd_now[1];
         end else if (aw_idx_now == IDX_SM_SZ_HI) begin
            sm_size_q[3] <= wd_now[0];
         end else if (aw_idx_now == IDX_SM_SZ_LO) begin
            sm_size_q[2:0] <= wd_now[7:5];
         end else if (aw_idx_now == IDX_VENDOR) begin
            vendor_q <= wd_now & 8'h7f; // R21
         end
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   wire logic ar_fire = s_axi_arvalid & s_axi_arready;
   wire logic [7:0] ar_idx = s_axi_araddr[9:2];
   logic [7:0] rd_byte;

   always_comb begin
      if (ar_idx == IDX_ISOLATION) begin
         rd_byte = iso_q & ISO_MASK; // R2
      end else if (ar_idx == IDX_RES_BYTE) begin
         rd_byte = res_in.data; // R7
      end else if (ar_idx == IDX_RES_STAT) begin
         rd_byte = {7'h00, res_in.valid}; // R8
      end else if (ar_idx == IDX_CSN) begin
         rd_byte = csn_q; // R9
      end else if (ar_idx == IDX_LDN) begin
         rd_byte = ldn_q;
      end else if (ar_idx == IDX_ACTIVATE) begin
         rd_byte = {7'h00, active_q}; // R10
      end else if (ar_idx == IDX_IO_RANGE_CHECK_ENABLE) begin
         rd_byte = {6'h00, io_range_check_enable_q};
      end else if (ar_idx == IDX_ROM_HI) begin
         rd_byte = {7'h06, rom_base_q[3]}; // R25
      end else if (ar_idx == IDX_ROM_LO) begin
         rd_byte = {rom_base_q[2:0], 5'h00};
      end else if (ar_idx == IDX_ROM_WIDTH) begin
         rd_byte = {6'h00, rom_wide_q, 1'b0};
      end else if (ar_idx == IDX_ROM_SZ_HI) begin
         rd_byte = {7'h7f, rom_size_q[3]}; // R25
      end else if (ar_idx == IDX_ROM_SZ_LO) begin
         rd_byte = {rom_size_q[2:0], 5'h00};
      end else if (ar_idx == IDX_SM_HI) begin
         rd_byte = {6'h03, sm_base_q[4:3]}; // R25
      end else if (ar_idx == IDX_SM_LO) begin
         rd_byte = {sm_base_q[2:0], 5'h00};
      end else if (ar_idx == IDX_SM_WIDTH) begin
         rd_byte = {6'h00, sm_wide_q, 1'b0};
      end else if (ar_idx == IDX_SM_SZ_HI) begin
         rd_byte = {7'h7f, sm_size_q[3]};
      end else if (ar_idx == IDX_SM_SZ_LO) begin
         rd_byte = {sm_size_q[2:0], 5'h00};
      end else if (ar_idx == IDX_IO_HI) begin
         rd_byte = {7'h01, io_base_q[3]}; // R25
      end else if (ar_idx == IDX_IO_LO) begin
         rd_byte = {io_base_q[2:0], 5'h00};
      end else if (ar_idx == IDX_IRQ_SEL) begin
         rd_byte = {4'h0, irq_sel_q};
      end else if (ar_idx == IDX_IRQ_SIG) begin
         rd_byte = {6'h00, ~irq_type_q, irq_type_q}; // R17
      end else if (ar_idx == IDX_DMA_SEL) begin
         rd_byte = {5'h00, dma_sel_q};
      end else if (ar_idx == IDX_VENDOR) begin
         rd_byte = vendor_q;
      end else begin
         rd_byte = BYTE_ZERO; // Write-only and unmapped read as zero
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
         res_take_q <= 1'b0;
      end else begin
         res_take_q <= ar_fire && ar_idx == IDX_RES_BYTE && res_in.valid; // R7
         if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= is_mapped(ar_idx) ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // ----------------------------------------
   // Interrupt and DMA routing
   // ----------------------------------------
   // Edge type drives high; level type drives low while asserted
   wire logic interrupt_polarity_indicator = dev_irq ^ irq_type_q; // R16
   logic [7:0] irq_d;
   logic [3:0] drq_d;

   always_comb begin
      irq_d = 8'h00;
      case (irq_sel_q)
         4'h3: irq_d[0] = 1'b1;
         4'h4: irq_d[1] = 1'b1;
         4'h5: irq_d[2] = 1'b1;
         4'h9: irq_d[3] = 1'b1;
         4'ha: irq_d[4] = 1'b1;
         4'hb: irq_d[5] = 1'b1;
         4'hd: irq_d[6] = 1'b1;
         4'he: irq_d[7] = 1'b1; // R14
         default: irq_d = 8'h00;
      endcase
      drq_d = 4'h0;
      case (dma_sel_q)
         3'h3: drq_d[0] = 1'b1;
         3'h5: drq_d[1] = 1'b1;
         3'h6: drq_d[2] = 1'b1;
         3'h7: drq_d[3] = 1'b1; // R18
         default: drq_d = 4'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_q <= 8'h00;
         drq_q <= 4'h0;
         rst_pulse_q <= 1'b0;
      end else begin
         irq_q <= active_q ? (irq_d & {8{interrupt_polarity_indicator}}) : 8'h00; // R15
         drq_q <= (active_q && bus_master) ? (drq_d & {4{dev_drq}}) : 4'h0; // R19
         rst_pulse_q <= do_rst_all;
      end
   end

   pcr_decode u_decode (
      .clk(clk),
      .rstn(rstn),
      .host_addr_raw(host_addr),
      .io_base_match(io_base_q),
      .rom_base_match(rom_base_q),
      .active(active_q),
      .io_hit(io_hit),
      .rom_hit(rom_hit)
   );

   assign irq_lines = irq_q;
   assign drq_lines = drq_q;
   assign logical_reset = rst_pulse_q;
   assign res_take = res_take_q;
   assign cfg_state = state_q;
   assign vendor_opts = vendor_q;
endmodule

/* pcr_pkg.sv */
// Package: register map, field positions and shared types for the PnP config bank
package pcr_pkg;

   // Register indices (printed offsets; byte address is index * 4)
   localparam logic [7:0] IDX_READ_PORT = 8'h00;
   localparam logic [7:0] IDX_ISOLATION = 8'h01;
   localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
   localparam logic [7:0] IDX_WAKE = 8'h03;
   localparam logic [7:0] IDX_RES_BYTE = 8'h04;
   localparam logic [7:0] IDX_RES_STAT = 8'h05;
   localparam logic [7:0] IDX_CSN = 8'h06;
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_IO_RANGE_CHECK_ENABLE = 8'h31;
   localparam logic [7:0] IDX_ROM_HI = 8'h40;
   localparam logic [7:0] IDX_ROM_LO = 8'h41;
   localparam logic [7:0] IDX_ROM_WIDTH = 8'h42;
   localparam logic [7:0] IDX_ROM_SZ_HI = 8'h43;
   localparam logic [7:0] IDX_ROM_SZ_LO = 8'h44;
   localparam logic [7:0] IDX_SM_HI = 8'h48;
   localparam logic [7:0] IDX_SM_LO = 8'h49;
   localparam logic [7:0] IDX_SM_WIDTH = 8'h4a;
   localparam logic [7:0] IDX_SM_SZ_HI = 8'h4b;
   localparam logic [7:0] IDX_SM_SZ_LO = 8'h4c;
   localparam logic [7:0] IDX_IO_HI = 8'h60;
   localparam logic [7:0] IDX_IO_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
   localparam logic [7:0] IDX_IRQ_SIG = 8'h71;
   localparam logic [7:0] IDX_DMA_SEL = 8'h74;
   localparam logic [7:0] IDX_VENDOR = 8'hf0;

   // Field positions
   localparam int CTL_CLR_CSN_BIT = 2;
   localparam int CTL_WAIT_KEY_BIT = 1;
   localparam int CTL_RST_ALL_BIT = 0;
   localparam int VND_LEGACY_BIT = 6;

   // Values after reset
   localparam logic [3:0] IRQ_SEL_RST = 4'h3;
   localparam logic [2:0] DMA_SEL_RST = 3'h4;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Key bytes, fixed address constants and AXI response codes
   localparam logic [7:0] KEY_STANDARD = 8'h6a;
   localparam logic [7:0] KEY_VENDOR = 8'h6b;
   localparam logic [1:0] IO_BASE_TOP = 2'h1;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PCR_WAIT_KEY,
      PCR_SLEEP,
      PCR_ISOLATE,
      PCR_CONFIG
   } pcr_state_t;

   // Fields loaded from the EEPROM reader at power-up
   typedef struct packed {
      logic [3:0] io_base_match;
      logic [3:0] irq_sel;
      logic irq_type;
      logic [2:0] dma_sel;
      logic [3:0] rom_base_match;
      logic [7:0] vendor;
   } pcr_load_t;

   // Resource byte offered by the EEPROM reader
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } pcr_res_t;

endpackage

/* pcr_decode.sv */
// Host address matching against the I/O and boot PROM base fields
module pcr_decode
   import pcr_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic [19:0] host_addr_raw, // Host address pins, asynchronous
   input wire logic [3:0] io_base_match, // I/O base field
   input wire logic [3:0] rom_base_match, // Boot PROM base field
   input wire logic active, // Device activated
   output logic io_hit, // Host address in I/O window
   output logic rom_hit // Host address in PROM window
);
   logic [19:0] meta_q;
   logic [19:0] sync_q;
   wire logic io_cmp;
   wire logic rom_cmp;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= host_addr_raw;
         sync_q <= meta_q;
      end
   end

   // Base 0x200 + 0x20 * field: bit 9 set, bits 8..5 equal field
   assign io_cmp = (sync_q[9:8] == {IO_BASE_TOP[0], io_base_match[3]}) &&
      (sync_q[7:5] == io_base_match[2:0]); // R12
   assign rom_cmp = (sync_q[16:13] == rom_base_match); // R20

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         io_hit <= 1'b0;
         rom_hit <= 1'b0;
      end else begin
         io_hit <= io_cmp & active;
         rom_hit <= rom_cmp & active;
      end
   end
endmodule

/* pcr_chk.sv */
// Concurrent checks on the PnP configuration bank ports
module pcr_chk
   import pcr_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rstn, // Reset
   input wire logic [9:0] s_axi_araddr, // Read addr
   input wire logic s_axi_arvalid, // Read valid
   input wire logic s_axi_arready, // Read ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic s_axi_rvalid, // Data valid
   input wire logic [7:0] key_byte, // Key
   input wire logic key_strobe, // Key strobe
   input wire pcr_res_t res_in, // Resource byte
   input wire logic res_take, // Byte taken
   input wire logic [7:0] irq_lines, // Irq lines
   input wire logic [3:0] drq_lines, // Dma lines
   input wire logic logical_reset, // Reset pulse
   input wire logic [1:0] cfg_state, // State
   input wire logic [7:0] vendor_opts // Vendor byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence key_seen(logic [7:0] k);
      cfg_state == 2'h0 && key_strobe && key_byte == k;
   endsequence
   AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
   AST_RDATA_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata high");
   AST_RES_TAKE: assert property (rd_taken ##0 (s_axi_araddr[9:2] == IDX_RES_BYTE && res_in.valid)
      |=> res_take) else $error("resource byte not taken");
   AST_LRST_PULSE: assert property (logical_reset |=> !logical_reset) else $error("reset pulse long");
   AST_IRQ_ONE: assert property ($onehot0(irq_lines)) else $error("several irq lines");
   AST_DRQ_ONE: assert property ($onehot0(drq_lines)) else $error("several dma lines");
   AST_VKEY: assert property (key_seen(KEY_VENDOR) |=> cfg_state == 2'h1) else $error("vendor key lost");
   AST_SKEY_LEGACY: assert property (key_seen(KEY_STANDARD) ##0 vendor_opts[VND_LEGACY_BIT]
      |=> cfg_state == 2'h0) else $error("standard key taken in legacy");
endmodule

bind pcr_bank pcr_chk u_chk (.*);

/* pcr_host_model.sv */
// Far-side model: EEPROM reader and key source
module pcr_host_model
   import pcr_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic res_take, // Byte taken
   output logic [7:0] key_byte, // Key byte
   output logic key_strobe, // Key strobe
   output logic eeprom_done, // Load pulse
   output logic eeprom_ok, // Checksum good
   output pcr_load_t eeprom_load, // Fields
   output pcr_res_t res_in // Resource byte
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      key_byte = 8'h00;
      key_strobe = 1'b0;
      eeprom_done = 1'b0;
      eeprom_ok = 1'b0;
      eeprom_load = '0;
      res_in = {1'b1, 8'ha5};
   end
   always @(posedge clk) if (res_take) res_in.data <= res_in.data + 8'h01;
   task automatic send_key(input logic [7:0] b);
      @(posedge clk);
      key_byte <= b;
      key_strobe <= 1'b1;
      @(posedge clk);
      key_byte <= ~b;
      key_strobe <= 1'b0;
   endtask
   task automatic load(input pcr_load_t ld);
      @(posedge clk);
      eeprom_ok <= 1'b1;
      eeprom_load <= ld;
      eeprom_done <= 1'b1;
      @(posedge clk);
      eeprom_done <= 1'b0;
   endtask
endmodule

/* pcr_bank_tb.sv */
// Self-checking bench for the PnP configuration bank
module pcr_bank_tb
   import pcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dev_irq = 1'b0, dev_drq = 1'b0, bus_master = 1'b0;
   logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [19:0] host_addr = 20'h00000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, key_strobe, eeprom_done;
   logic eeprom_ok, res_take, logical_reset, io_hit, rom_hit, isolation_bit = 1'b0;
   logic [1:0] s_axi_bresp, s_axi_rresp, cfg_state;
   logic [7:0] key_byte, irq_lines, vendor_opts;
   logic [3:0] drq_lines;
   pcr_load_t eeprom_load;
   pcr_res_t res_in;
   int mismatches = 0, n_checks = 0, cyc = 0;
   pcr_bank dut (.*, .s_axi_wstrb(4'h1));
   pcr_host_model hm (.*);
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test;
      if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic a = 1'b1, w = 1'b1, b = 1'b1;
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (b) begin
         @(negedge clk);
         a = a & ~s_axi_awready;
         w = w & ~s_axi_wready;
         b = ~s_axi_bvalid;
         if (!b) chk(s_axi_bresp, er);
         @(posedge clk);
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, w, b};
      end
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
      logic a = 1'b1, r = 1'b1;
      @(posedge clk);
      s_axi_araddr <= {idx, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      while (r) begin
         @(negedge clk);
         a = a & ~s_axi_arready;
         r = ~s_axi_rvalid;
         if (!r) chk(s_axi_rdata, {24'h0, e});
         if (!r) chk(s_axi_rresp, er);
         @(posedge clk);
         {s_axi_arvalid, s_axi_rready} <= {a, r};
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd(IDX_IRQ_SEL, 8'h03, AXI_OKAY);
      rd(IDX_IRQ_SIG, 8'h02, AXI_OKAY);
      rd(IDX_DMA_SEL, 8'h04, AXI_OKAY);
      rd(8'h08, 8'h00, AXI_SLVERR);
      wr(8'h08, 8'h5a, AXI_SLVERR);
      hm.load({4'h3, 4'h3, 1'b0, 3'h4, 4'h0, 8'h00});
      hm.send_key(KEY_VENDOR);
      @(negedge clk);
      chk(cfg_state, 2'h1);
      wr(IDX_WAKE, 8'h00, AXI_OKAY);
      chk(cfg_state, 2'h2);
      isolation_bit <= 1'b1;
      rd(IDX_ISOLATION, 8'h01, AXI_OKAY);
      wr(IDX_CSN, 8'h05, AXI_OKAY);
      rd(IDX_CSN, 8'h05, AXI_OKAY);
      rd(IDX_IO_LO, 8'h60, AXI_OKAY);
      rd(IDX_IO_HI, 8'h02, AXI_OKAY);
      rd(IDX_RES_STAT, 8'h01, AXI_OKAY);
      rd(IDX_RES_BYTE, 8'ha5, AXI_OKAY);
      rd(IDX_RES_BYTE, 8'ha6, AXI_OKAY);
      {dev_irq, dev_drq, bus_master} <= 3'b111;
      host_addr <= 20'h00260;
      repeat (4) @(negedge clk);
      chk(irq_lines, 8'h00);
      wr(IDX_ACTIVATE, 8'hff, AXI_OKAY);
      rd(IDX_ACTIVATE, 8'h01, AXI_OKAY);
      wr(IDX_IO_RANGE_CHECK_ENABLE, 8'hff, AXI_OKAY);
      rd(IDX_IO_RANGE_CHECK_ENABLE, 8'h03, AXI_OKAY);
      repeat (4) @(negedge clk);
      chk({irq_lines, drq_lines, io_hit, rom_hit}, {8'h01, 4'h0, 1'b1, 1'b1});
      wr(IDX_DMA_SEL, 8'h07, AXI_OKAY);
      wr(IDX_IRQ_SEL, 8'h0e, AXI_OKAY);
      @(negedge clk);
      chk({irq_lines, drq_lines}, {8'h80, 4'h8});
      wr(IDX_IRQ_SIG, 8'h01, AXI_OKAY);
      rd(IDX_IRQ_SIG, 8'h01, AXI_OKAY);
      wr(IDX_CFG_CTRL, 8'h01, AXI_OKAY);
      rd(IDX_ACTIVATE, 8'h00, AXI_OKAY);
      chk(irq_lines, 8'h00);
      wr(IDX_CFG_CTRL, 8'h04, AXI_OKAY);
      rd(IDX_CSN, 8'h00, AXI_OKAY);
      wr(IDX_VENDOR, 8'h40, AXI_OKAY);
      wr(IDX_CFG_CTRL, 8'h02, AXI_OKAY);
      chk({cfg_state, vendor_opts}, {2'h0, 8'h40});
      hm.send_key(KEY_STANDARD);
      @(negedge clk);
      chk(cfg_state, 2'h0);
      hm.send_key(KEY_VENDOR);
      @(negedge clk);
      chk(cfg_state, 2'h1);
      finish_test();
   end
endmodule
